// ==== cbts_map.svh ====
// register offsets, field reset values and timing counts of the bit timer
`ifndef CBTS_MAP_SVH
`define CBTS_MAP_SVH

// ---------------------------------------------------------------------
// register offsets (byte address, low eight address bits decoded)
// ---------------------------------------------------------------------
`define CBTS_OFS_TIMING 8'h00
`define CBTS_OFS_CTRL 8'h04
`define CBTS_OFS_STATUS 8'h08

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define CBTS_CTRL_EN_BIT 0
`define CBTS_ST_RX_BIT 0
`define CBTS_ST_IDLE_BIT 1
`define CBTS_ST_HARD_BIT 2
`define CBTS_ST_RESYNC_BIT 3

// ---------------------------------------------------------------------
// reset values: 5 clocks per quantum, 20 quanta per bit
// ---------------------------------------------------------------------
`define CBTS_RST_PRESC 8'h04
`define CBTS_RST_PROP 4'h7
`define CBTS_RST_PH1 4'h9
`define CBTS_RST_PH2 4'h3
`define CBTS_RST_SJW 2'h1
`define CBTS_RST_EN 1'h0

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define CBTS_BIT_TIME_NS 4000
`define CBTS_CLK_PERIOD_NS 40
`define CBTS_CLKS_PER_BIT (`CBTS_BIT_TIME_NS / `CBTS_CLK_PERIOD_NS)
`define CBTS_IDLE_BITS 4'hB
`define CBTS_HSIZE_WORD 3'h2

`endif

// ==== cbts_pkg.sv ====
// types shared by the bit timer modules
package cbts_pkg;

    // -----------------------------------------------------------------
    // timing register layout
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [9:0] rsvd;
        logic [1:0] sjw;
        logic [3:0] ph2;
        logic [3:0] ph1;
        logic [3:0] prop;
        logic [7:0] presc;
    } cbts_timing_t;

    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_PROP,
        SEG_PH1,
        SEG_PH2
    } cbts_seg_t;

    // -----------------------------------------------------------------
    // quantum generator state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } cbts_tq_state_t;

    // -----------------------------------------------------------------
    // top state
    // -----------------------------------------------------------------
    typedef struct packed {
        cbts_timing_t timing;
        logic en;
        cbts_seg_t seg;
        logic [4:0] cnt;
        logic [1:0] ext;
        logic [1:0] cut;
        logic synced;
        logic last_sample;
        logic prev_rx;
        logic [3:0] idle_cnt;
        logic can_tx;
        logic rx_bit;
        logic sample;
        logic bit_start;
        logic hard_seen;
        logic resync_seen;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] dp_addr;
        logic hready;
        logic [31:0] hrdata;
        logic hresp;
    } cbts_state_t;

endpackage : cbts_pkg

// ==== cbts_tq_gen.sv ====
// time quantum tick generator with restart
`timescale 1ns/10ps
`include "cbts_map.svh"

module cbts_tq_gen import cbts_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] presc,
    input wire logic restart,
    output logic tick
);

    cbts_tq_state_t st_q;
    cbts_tq_state_t st_d;

    // -----------------------------------------------------------------
    // one tick every presc+1 clocks
    // -----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (restart) begin
            st_d.cnt = 8'h00;
        end else if (st_q.cnt >= presc) begin
            st_d.cnt = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '{cnt: 8'h00, tick: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

    a_tq_gap: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_q.tick && presc != 8'h00 |=> !st_q.tick)
        else $error("quantum ticks closer than the prescaler allows");

endmodule : cbts_tq_gen

// ==== cbts_top.sv ====
// bit timing, synchronisation and bus level logic with ahb-lite registers
`timescale 1ns/10ps
`include "cbts_map.svh"

// How it works
// - bit lasts four microseconds at reset settings, 250 kbit/s
// - transmit output stays recessive when idle or sending recessive
// - a dominant bit is actively driven for its whole bit time
// - received level is dominant if any node, ourselves included, drives it
// - each bit opens with a one-quantum synchronisation segment
// - propagation segment follows, its length a programmable quantum count
// - resync lengthens phase one or shortens phase two
// - bus is sampled at end of phase one as the bit value
// - at most one synchronisation per bit time
// - edge used only if previous sample was recessive
// - qualifying falling edge after idle restarts bit timing there
// - other edges resync; transmitter ignores edges with positive error
// - each resync moves phase segments by at most jump width

module cbts_top import cbts_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic can_rx,
    output logic can_tx,
    input wire logic tx_active,
    input wire logic tx_bit,
    output logic rx_bit,
    output logic sample_pulse,
    output logic bit_start
);

    cbts_state_t st_q;
    cbts_state_t st_d;
    logic tq_tick;
    logic tq_restart;
    logic rx_level;
    logic fall;
    logic qual;
    logic idle;
    logic hard;
    logic pos_reg;
    logic rs_pos;
    logic rs_neg;
    logic rs_zero;
    logic sync_evt;
    logic accept;
    logic [4:0] pos_err;
    logic [4:0] ph2_rem;
    logic [4:0] ph1_end;
    logic [4:0] ph2_end;
    logic [4:0] cnt_inc;
    logic [31:0] rd_val;

    // -----------------------------------------------------------------
    // quantum generator
    // -----------------------------------------------------------------
    cbts_tq_gen u_tq (
        .hclk(hclk),
        .hresetn(hresetn),
        .presc(st_q.timing.presc),
        .restart(tq_restart),
        .tick(tq_tick)
    );

    // -----------------------------------------------------------------
    // edge qualification
    // -----------------------------------------------------------------
    assign rx_level = can_rx & st_q.can_tx;
    assign fall = st_q.prev_rx & ~rx_level;
    assign qual = fall & st_q.last_sample & ~st_q.synced & st_q.en;
    assign idle = st_q.idle_cnt == `CBTS_IDLE_BITS;
    assign hard = qual & idle;
    assign pos_reg = st_q.seg == SEG_PROP || st_q.seg == SEG_PH1;
    assign rs_pos = qual & ~idle & pos_reg & ~tx_active;
    assign rs_neg = qual & ~idle & (st_q.seg == SEG_PH2);
    assign rs_zero = qual & ~idle & (st_q.seg == SEG_SYNC);
    assign sync_evt = hard | rs_pos | rs_neg | rs_zero;
    assign tq_restart = hard | ~st_q.en;

    // -----------------------------------------------------------------
    // segment arithmetic
    // -----------------------------------------------------------------
    assign cnt_inc = st_q.cnt + 5'h01;
    assign pos_err = (st_q.seg == SEG_PROP) ? cnt_inc :
                     cnt_inc + {1'b0, st_q.timing.prop};
    assign ph2_rem = {1'b0, st_q.timing.ph2} - st_q.cnt;
    assign ph1_end = {1'b0, st_q.timing.ph1} + {3'h0, st_q.ext};
    assign ph2_end = {1'b0, st_q.timing.ph2} - {3'h0, st_q.cut};
    assign accept = hsel & htrans[1] & hready;

    // -----------------------------------------------------------------
    // register read mux
    // -----------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        case (st_q.dp_addr)
            `CBTS_OFS_TIMING: begin
                rd_val = st_q.timing;
                rd_val[31:22] = 10'h000;
            end
            `CBTS_OFS_CTRL: begin
                rd_val[`CBTS_CTRL_EN_BIT] = st_q.en;
            end
            `CBTS_OFS_STATUS: begin
                rd_val[`CBTS_ST_RX_BIT] = st_q.rx_bit;
                rd_val[`CBTS_ST_IDLE_BIT] = idle;
                rd_val[`CBTS_ST_HARD_BIT] = st_q.hard_seen;
                rd_val[`CBTS_ST_RESYNC_BIT] = st_q.resync_seen;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.sample = 1'b0;
        st_d.bit_start = 1'b0;
        st_d.prev_rx = rx_level;
        st_d.hresp = 1'b0;

        // bus slave: writes complete in the data phase
        st_d.wr_pend = 1'b0;
        if (st_q.wr_pend) begin
            case (st_q.dp_addr)
                `CBTS_OFS_TIMING: begin
                    st_d.timing = hwdata;
                    st_d.timing.rsvd = 10'h000;
                end
                `CBTS_OFS_CTRL: begin
                    st_d.en = hwdata[`CBTS_CTRL_EN_BIT];
                end
                `CBTS_OFS_STATUS: begin
                    // write one to clear; hardware sets below win
                    if (hwdata[`CBTS_ST_HARD_BIT]) begin
                        st_d.hard_seen = 1'b0;
                    end
                    if (hwdata[`CBTS_ST_RESYNC_BIT]) begin
                        st_d.resync_seen = 1'b0;
                    end
                end
                default: begin
                    st_d.wr_pend = 1'b0;
                end
            endcase
        end
        // reads take one wait state so data come from a flop
        if (st_q.rd_pend) begin
            st_d.hrdata = rd_val;
            st_d.hready = 1'b1;
            st_d.rd_pend = 1'b0;
        end
        if (accept) begin
            st_d.dp_addr = haddr[7:0];
            if (hwrite) begin
                st_d.wr_pend = hsize == `CBTS_HSIZE_WORD;
            end else begin
                st_d.rd_pend = 1'b1;
                st_d.hready = 1'b0;
            end
        end

        // bit timing
        if (!st_q.en) begin
            st_d.seg = SEG_SYNC;
            st_d.cnt = 5'h00;
            st_d.ext = 2'h0;
            st_d.cut = 2'h0;
            st_d.synced = 1'b0;
            st_d.can_tx = 1'b1;
            st_d.idle_cnt = 4'h0;
        end else if (hard) begin
            // the edge becomes the new synchronisation segment
            st_d.seg = SEG_SYNC;
            st_d.cnt = 5'h00;
            st_d.ext = 2'h0;
            st_d.cut = 2'h0;
            st_d.synced = 1'b1;
            st_d.bit_start = 1'b1;
            st_d.can_tx = tx_active ? tx_bit : 1'b1;
            st_d.hard_seen = 1'b1;
        end else begin
            if (rs_pos) begin
                // late edge: stretch phase one
                st_d.ext = (pos_err > {3'h0, st_q.timing.sjw}) ?
                           st_q.timing.sjw : pos_err[1:0];
                st_d.synced = 1'b1;
                st_d.resync_seen = 1'b1;
            end
            if (rs_neg) begin
                // early edge: cut phase two short
                st_d.cut = (ph2_rem > {3'h0, st_q.timing.sjw}) ?
                           st_q.timing.sjw : ph2_rem[1:0];
                st_d.synced = 1'b1;
                st_d.resync_seen = 1'b1;
            end
            if (rs_zero) begin
                st_d.synced = 1'b1;
            end
            if (tq_tick) begin
                case (st_q.seg)
                    SEG_SYNC: begin
                        st_d.seg = SEG_PROP;
                        st_d.cnt = 5'h00;
                    end
                    SEG_PROP: begin
                        if (cnt_inc >= {1'b0, st_q.timing.prop}) begin
                            st_d.seg = SEG_PH1;
                            st_d.cnt = 5'h00;
                        end else begin
                            st_d.cnt = cnt_inc;
                        end
                    end
                    SEG_PH1: begin
                        if (cnt_inc >= ph1_end) begin
                            st_d.seg = SEG_PH2;
                            st_d.cnt = 5'h00;
                            st_d.sample = 1'b1;
                            st_d.rx_bit = rx_level;
                            st_d.last_sample = rx_level;
                            if (!rx_level) begin
                                st_d.idle_cnt = 4'h0;
                            end else if (!idle) begin
                                st_d.idle_cnt = st_q.idle_cnt + 4'h1;
                            end
                        end else begin
                            st_d.cnt = cnt_inc;
                        end
                    end
                    SEG_PH2: begin
                        if (cnt_inc >= ph2_end) begin
                            st_d.seg = SEG_SYNC;
                            st_d.cnt = 5'h00;
                            st_d.ext = 2'h0;
                            st_d.cut = 2'h0;
                            st_d.synced = 1'b0;
                            st_d.bit_start = 1'b1;
                            st_d.can_tx = tx_active ? tx_bit : 1'b1;
                        end else begin
                            st_d.cnt = cnt_inc;
                        end
                    end
                    default: begin
                        st_d.seg = SEG_SYNC;
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            st_q.timing <= '{rsvd: 10'h000, sjw: `CBTS_RST_SJW,
                             ph2: `CBTS_RST_PH2, ph1: `CBTS_RST_PH1,
                             prop: `CBTS_RST_PROP,
                             presc: `CBTS_RST_PRESC};
            st_q.en <= `CBTS_RST_EN;
            st_q.seg <= SEG_SYNC;
            st_q.last_sample <= 1'b1;
            st_q.prev_rx <= 1'b1;
            st_q.can_tx <= 1'b1;
            st_q.rx_bit <= 1'b1;
            st_q.hready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign hreadyout = st_q.hready;
    assign hrdata = st_q.hrdata;
    assign hresp = st_q.hresp;
    assign can_tx = st_q.can_tx;
    assign rx_bit = st_q.rx_bit;
    assign sample_pulse = st_q.sample;
    assign bit_start = st_q.bit_start;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_idle_recessive: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !st_q.en |=> can_tx)
        else $error("transmit not recessive while disabled");

    a_dominant_drive: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_q.bit_start |->
            can_tx == ($past(tx_active) ? $past(tx_bit) : 1'b1))
        else $error("bit start did not load the transmit level");

    a_wired_and: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_q.sample |-> rx_bit == ($past(can_rx) && $past(can_tx)))
        else $error("dominant level not resolved on the bus");

    a_sync_one_tq: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_q.en && !hard && tq_tick && st_q.seg == SEG_SYNC
            |=> st_q.seg == SEG_PROP)
        else $error("sync segment longer than one quantum");

    a_sample_ph1_end: assert property (
        @(posedge hclk) disable iff (!hresetn)
        st_q.sample |-> $past(st_q.seg) == SEG_PH1 &&
            st_q.seg == SEG_PH2 && rx_bit == $past(rx_level))
        else $error("sample not taken at end of phase one");

    a_one_sync_bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sync_evt && !(tq_tick && st_q.seg == SEG_PH2 && cnt_inc >= ph2_end)
            |=> st_q.synced ##1 !sync_evt)
        else $error("second synchronisation in one bit");

    a_edge_qualify: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sync_evt |-> st_q.last_sample && !rx_level && st_q.prev_rx)
        else $error("synchronised on an edge that does not qualify");

    a_hard_restart: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hard |=> st_q.seg == SEG_SYNC && st_q.bit_start && st_q.cnt == 5'h00)
        else $error("hard sync did not restart the bit");

    a_tx_no_pos: assert property (
        @(posedge hclk) disable iff (!hresetn)
        qual && !idle && pos_reg && tx_active && !tq_tick
            |=> st_q.ext == $past(st_q.ext) && !st_q.resync_seen ||
                $past(st_q.resync_seen))
        else $error("transmitter resynchronised on a late edge");

    a_jump_bound: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rs_pos || rs_neg |=> st_q.ext <= $past(st_q.timing.sjw) &&
            st_q.cut <= $past(st_q.timing.sjw))
        else $error("phase jump exceeds the jump width");

endmodule : cbts_top

// ==== cbts_far_node.sv ====
// far-side node that sends a bit pattern onto the shared bus
`timescale 1ns/10ps

module cbts_far_node (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [15:0] pattern,
    input wire logic [7:0] bit_clks,
    input wire logic can_tx,
    output logic can_rx,
    output logic busy
);
    logic [15:0] sh_q;
    logic [4:0] left_q;
    logic [7:0] cnt_q;

    // ---------------------------------------------------------------
    // wired bus: pulled recessive, any dominant driver wins
    // ---------------------------------------------------------------
    assign busy = left_q != 5'h00;
    assign can_rx = can_tx & (busy ? sh_q[0] : 1'b1);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_q <= 5'h00;
            sh_q <= 16'hFFFF;
            cnt_q <= 8'h00;
        end else if (start) begin
            sh_q <= pattern;
            left_q <= 5'h10;
            cnt_q <= 8'h00;
        end else if (busy) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == bit_clks - 8'h01) begin
                cnt_q <= 8'h00;
                sh_q <= sh_q >> 1;
                left_q <= left_q - 5'h01;
            end
        end
    end
endmodule : cbts_far_node

// ==== cbts_top_tb.sv ====
// self-checking bench for the bit timer
`timescale 1ns/10ps
`include "cbts_map.svh"

module cbts_top_tb import cbts_pkg::*; ;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, can_rx, can_tx;
    logic tx_active, tx_bit, rx_bit, sample_pulse, bit_start;
    logic start, busy, rd_ph, b;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] pattern;
    logic [7:0] bit_clks;
    logic [63:0] rdq[$];
    logic rxq[$];
    int fail_count, n_checks, seed, i, n;

    cbts_top cbts_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .can_rx(can_rx), .can_tx(can_tx),
        .tx_active(tx_active), .tx_bit(tx_bit), .rx_bit(rx_bit),
        .sample_pulse(sample_pulse), .bit_start(bit_start));
    cbts_far_node cbts_far_node_i (.hclk(hclk), .hresetn(hresetn),
        .start(start), .pattern(pattern), .bit_clks(bit_clks),
        .can_tx(can_tx), .can_rx(can_rx), .busy(busy));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", what, e, g);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    function automatic logic ev(input int w);
        return w == 0 ? hreadyout : (w == 1 ? sample_pulse : bit_start);
    endfunction : ev

    task automatic wait_ev(input int w, input int lim);
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (ev(w) !== 1'b1 && k < lim);
        if (ev(w) !== 1'b1) begin
            fail_count++;
            complete_run();
        end
    endtask : wait_ev

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] m);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ev(0, 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        if (!wr)
            rdq.push_back({m, d});
        wait_ev(0, 50);
    endtask : ahb

    // ---------------------------------------------------------------
    // result watcher
    // ---------------------------------------------------------------
    always @(posedge hclk) begin
        if (rd_ph && hreadyout) begin
            check("hrdata", rdq[0][31:0], hrdata & rdq[0][63:32]);
            check("hresp", 32'h0, 32'(hresp));
            void'(rdq.pop_front());
        end
        if (!hresetn)
            rd_ph <= 1'b0;
        else if (hsel && htrans[1] && hreadyout && !hwrite)
            rd_ph <= 1'b1;
        else if (hreadyout)
            rd_ph <= 1'b0;
        if (sample_pulse && rxq.size() > 0) begin
            check("rx_bit", 32'(rxq[0]), 32'(rx_bit));
            void'(rxq.pop_front());
        end
    end

    initial begin
        seed = 32'hc129;
        {hresetn, hsel, hwrite, tx_active, start} = 5'h00;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = `CBTS_HSIZE_WORD;
        tx_bit = 1'b1;
        pattern = 16'hFFFF;
        bit_clks = 8'h64;
        fail_count = 0;
        n_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("can_tx", 32'h1, 32'(can_tx));
        ahb(0, `CBTS_OFS_TIMING, {10'h0, `CBTS_RST_SJW, `CBTS_RST_PH2,
            `CBTS_RST_PH1, `CBTS_RST_PROP, `CBTS_RST_PRESC}, '1);
        ahb(0, `CBTS_OFS_CTRL, 32'h0, '1);
        ahb(0, `CBTS_OFS_STATUS, 32'h1, 32'hF);
        ahb(0, 8'h0C, 32'h0, '1);
        hsize <= 3'h0;
        ahb(1, `CBTS_OFS_TIMING, 32'h0, '1);
        hsize <= `CBTS_HSIZE_WORD;
        ahb(0, `CBTS_OFS_TIMING, 32'h0013_9704, '1);
        ahb(1, `CBTS_OFS_CTRL, 32'h1, '1);
        wait_ev(2, 300);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (bit_start !== 1'b1 && n < 300);
        check("bit_clks", `CBTS_CLKS_PER_BIT, n);
        repeat (12) wait_ev(1, 300);
        ahb(0, `CBTS_OFS_STATUS, 32'h2, 32'h2);
        // received frame from a slightly slow far node
        wait_ev(1, 300);
        start <= 1'b1;
        pattern <= {11'($random(seed)), 5'b01110};
        bit_clks <= 8'h66;
        @(posedge hclk);
        start <= 1'b0;
        for (i = 0; i < 16; i++)
            rxq.push_back(pattern[i]);
        repeat (17) wait_ev(1, 300);
        ahb(0, `CBTS_OFS_STATUS, 32'hC, 32'hC);
        ahb(1, `CBTS_OFS_STATUS, 32'hC, '1);
        ahb(0, `CBTS_OFS_STATUS, 32'h0, 32'hC);
        // own transmitted bits seen back through the bus
        wait_ev(1, 300);
        b = 1'b0;
        tx_active <= 1'b1;
        tx_bit <= b;
        @(posedge hclk);
        rxq.push_back(b);
        for (i = 0; i < 8; i++) begin
            wait_ev(1, 300);
            b = (i == 7) ? 1'b1 : 1'($random(seed));
            tx_bit <= b;
            rxq.push_back(b);
        end
        wait_ev(1, 300);
        tx_bit <= 1'b0;
        ahb(1, `CBTS_OFS_CTRL, 32'h0, '1);
        repeat (120) @(posedge hclk);
        check("can_tx", 32'h1, 32'(can_tx));
        // sixteen-quantum split, one clock per quantum
        tx_active <= 1'b0;
        ahb(1, `CBTS_OFS_TIMING, 32'h0012_9400, '1);
        ahb(0, `CBTS_OFS_TIMING, 32'h0012_9400, '1);
        ahb(1, `CBTS_OFS_CTRL, 32'h1, '1);
        wait_ev(2, 300);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (bit_start !== 1'b1 && n < 300);
        check("bit_clks", 32'h10, n);
        ahb(1, `CBTS_OFS_CTRL, 32'h0, '1);
        check("queues", 32'h0, rdq.size() + rxq.size());
        complete_run();
    end
endmodule : cbts_top_tb
